// ### hw/ascd_device.sv
/*
  device end: decodes command frames on the serial link, holds the
  byte register file, lock state and crc error flag.
  assumes host drives data on sclk rise and samples on sclk fall.
*/
`timescale 1ns/10ps
`default_nettype none
module ascd_device
  import ascd_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'ha0  // value arbitrary
) (
  input wire logic clk,                  // 10 mhz system clock
  input wire logic arst_n,               // async reset, low active
  ascd_if.dev link,                      // serial link
  input wire logic ready_n,              // shown on dout between frames
  input wire logic cal_wr,               // calibration result write
  input wire logic [ADDR_W-1:0] cal_addr, // calibration register index
  input wire logic [7:0] cal_data,       // calibration result byte
  output logic sys_ofs_cal,              // start pulse
  output logic fs_cal,                   // start pulse
  output logic self_ofs_cal,             // start pulse
  output logic conv_restart,             // restart pulse
  output logic locked,                   // write lock level
  output logic check_error_flag,         // sticky crc error
  output logic crc_mode                  // crc framing enabled
);
  // ---------------------------------
  // pin synchronisers
  // ---------------------------------
  logic sclk_rise;
  logic sclk_fall;
  logic cs_s;
  logic din_s;

  ascd_sync_edge #(.INIT(1'b0)) u_sclk (
    .clk(clk), .arst_n(arst_n), .d(link.sclk),
    .q(), .rise(sclk_rise), .fall(sclk_fall));
  ascd_sync_edge #(.INIT(1'b1)) u_cs (
    .clk(clk), .arst_n(arst_n), .d(link.cs_n),
    .q(cs_s), .rise(), .fall());
  ascd_sync_edge #(.INIT(1'b0)) u_din (
    .clk(clk), .arst_n(arst_n), .d(link.din),
    .q(din_s), .rise(), .fall());

  // ---------------------------------
  // state
  // ---------------------------------
  logic [7:0] regs [NUM_REGS];
  logic [2:0] bit_reg;
  logic [2:0] idx_reg;
  logic [6:0] rx_reg;
  logic [7:0] op_reg;
  logic [7:0] arg_reg;
  logic [7:0] tx_reg;
  logic first_reg;
  logic ok_reg;
  logic lock_reg;
  logic err_reg;
  logic dout_reg;
  logic sys_reg;
  logic fs_reg;
  logic self_reg;
  logic restart_reg;

  // ---------------------------------
  // decode
  // ---------------------------------
  logic [7:0] rx_byte;
  logic byte_done;
  logic crc_en;
  logic [7:0] cmd_crc;
  logic crc_match;
  logic exec;
  logic [7:0] cur_arg;
  logic [4:0] op_addr;
  logic addr_ok;
  logic wr_cmd;
  logic cal_ok;
  logic [7:0] rd_val;
  logic [7:0] rd_out;
  logic [2:0] nxt_idx;
  logic [7:0] tx_next;
  logic err_set;
  logic err_clr;

  // a byte ends on the eighth falling edge inside a frame
  assign rx_byte = {rx_reg, din_s};
  assign byte_done = sclk_fall & ~cs_s & (bit_reg == 3'd7);
  assign crc_en = regs[REG_MODE3][MODE3_CRC_BIT];
  assign cmd_crc = crc8(crc8(CRC_SEED, op_reg), arg_reg);
  assign crc_match = rx_byte == cmd_crc;

  // no-crc frames act after byte two, crc frames after a good byte three
  assign exec = byte_done & ((~crc_en & (idx_reg == 3'd1))
              | (crc_en & (idx_reg == 3'd2) & crc_match));
  assign cur_arg = (idx_reg == 3'd1) ? rx_byte : arg_reg;
  assign op_addr = op_reg[4:0];
  assign addr_ok = op_addr < 5'(NUM_REGS);
  // lock blocks command writes; id is read only
  assign wr_cmd = exec & op_is_wr(op_reg) & ~lock_reg & addr_ok
                & (op_addr != REG_ID);
  assign cal_ok = cal_wr & ~lock_reg & (cal_addr < 5'(NUM_REGS));

  // read mux; status shows live lock and error bits
  assign rd_val = ~addr_ok ? OUT_RANGE_BYTE :
                  (op_addr == REG_ID) ? DEV_ID :
                  (op_addr == REG_STATUS) ?
                    {lock_reg, err_reg, regs[REG_STATUS][5:0]} :
                  regs[op_addr];
  // reads ignore lock; a crc-rejected read returns an idle data byte
  assign rd_out = (op_is_rd(op_reg) & (ok_reg | ~crc_en))
                ? rd_val : IDLE_BYTE;

  // byte to present next, by position in the frame
  assign nxt_idx = idx_reg + 3'd1;
  assign tx_next = (nxt_idx == 3'd1) ? rx_byte :
                   (~crc_en & (nxt_idx == 3'd2)) ? rd_out :
                   (crc_en & (nxt_idx == 3'd2)) ? rx_byte :
                   (crc_en & (nxt_idx == 3'd3)) ? cmd_crc :
                   (crc_en & (nxt_idx == 3'd4)) ? rd_out :
                   (crc_en & (nxt_idx == 3'd5)) ? crc8(CRC_SEED, rd_out) :
                   IDLE_BYTE;

  // error set wins over a status write that clears it
  assign err_set = byte_done & crc_en & (idx_reg == 3'd2) & ~crc_match;
  assign err_clr = wr_cmd & (op_addr == REG_STATUS) & ~cur_arg[STAT_ERR_BIT];

  // ---------------------------------
  // framing and shifting
  // ---------------------------------
  // cs high parks the counters so the next byte is an opcode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_reg <= 3'd0;
      idx_reg <= 3'd0;
      rx_reg <= 7'd0;
      tx_reg <= IDLE_BYTE;
      first_reg <= 1'b1;
    end else if (cs_s) begin
      bit_reg <= 3'd0;
      idx_reg <= 3'd0;
      tx_reg <= IDLE_BYTE;
      first_reg <= 1'b1;
    end else if (sclk_fall) begin
      rx_reg <= rx_byte[6:0];
      bit_reg <= bit_reg + 3'd1;
      if (byte_done) begin
        idx_reg <= (idx_reg == 3'd7) ? idx_reg : nxt_idx;
        tx_reg <= tx_next;
        first_reg <= 1'b1;
      end
    end else if (sclk_rise) begin
      // the first rise of a byte keeps the msb already on the pin
      first_reg <= 1'b0;
      if (!first_reg) begin
        tx_reg <= {tx_reg[6:0], 1'b1};
      end
    end
  end

  // command bytes and crc verdict
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_reg <= 8'h00;
      arg_reg <= 8'h00;
      ok_reg <= 1'b0;
    end else if (byte_done) begin
      if (idx_reg == 3'd0) begin
        op_reg <= rx_byte;
        ok_reg <= 1'b0;
      end
      if (idx_reg == 3'd1) begin
        arg_reg <= rx_byte;
      end
      if (idx_reg == 3'd2) begin
        ok_reg <= crc_match;
      end
    end
  end

  // ---------------------------------
  // register file, lock and error flag
  // ---------------------------------
  // one write per command; calibration loads yield to commands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RST[i];
      end
    end else if (wr_cmd) begin
      regs[op_addr] <= cur_arg;
    end else if (cal_ok) begin
      regs[cal_addr] <= cal_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (exec & (op_reg == OP_LOCK)) begin
        lock_reg <= 1'b1;
      end else if (exec & (op_reg == OP_UNLOCK)) begin
        lock_reg <= 1'b0;
      end
      if (err_set) begin
        err_reg <= 1'b1;
      end else if (err_clr) begin
        err_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------
  // pulses and pin
  // ---------------------------------
  // calibration starts are one-cycle pulses; the engine is outside
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_reg <= 1'b0;
      fs_reg <= 1'b0;
      self_reg <= 1'b0;
      restart_reg <= 1'b0;
      dout_reg <= 1'b1;
    end else begin
      sys_reg <= exec & (op_reg == OP_SYS_OFS_CAL);
      fs_reg <= exec & (op_reg == OP_FS_CAL);
      self_reg <= exec & (op_reg == OP_SELF_OFS_CAL);
      restart_reg <= wr_cmd & RESTART_MASK[op_addr];
      dout_reg <= cs_s ? ready_n : tx_reg[7];
    end
  end

  assign link.dout = dout_reg;
  assign sys_ofs_cal = sys_reg;
  assign fs_cal = fs_reg;
  assign self_ofs_cal = self_reg;
  assign conv_restart = restart_reg;
  assign locked = lock_reg;
  assign check_error_flag = err_reg;
  assign crc_mode = crc_en;
endmodule // ascd_device
`default_nettype wire

// ### hw/ascd_host.sv
/*
  host end: runs one command frame per request, makes sclk by a
  divider, checks echoes and crc bytes, returns read data.
  assumes crc_mode matches the device crc framing setting.
*/
`timescale 1ns/10ps
`default_nettype none
module ascd_host
  import ascd_pkg::*;
#(
  parameter int HALF_CLKS = SCLK_HALF_CLKS  // clk cycles per sclk half
) (
  input wire logic clk,          // 10 mhz system clock
  input wire logic arst_n,       // async reset, low active
  ascd_if.host link,             // serial link
  input wire logic cmd_valid,    // request present
  output logic cmd_ready,        // idle, request taken
  input wire logic [7:0] cmd_op, // opcode byte
  input wire logic [7:0] cmd_arg, // second byte
  input wire logic crc_mode,     // use crc framing
  output logic rsp_valid,        // frame finished pulse
  output logic [7:0] rsp_data,   // read data byte
  output logic rsp_err           // echo or crc mismatch
);
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_SHIFT, H_TAIL, H_GAP} ascd_hstate_t;
  ascd_hstate_t state_reg;
  logic [15:0] div_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic din_reg;
  logic [2:0] bit_reg;
  logic [2:0] idx_reg;
  logic [2:0] len_reg;
  logic [7:0] tx_reg;
  logic [6:0] rx_reg;
  logic [7:0] op_reg;
  logic [7:0] arg_reg;
  logic [7:0] data_reg;
  logic mode_reg;
  logic err_reg;
  logic valid_reg;
  logic dout_s;

  ascd_sync_edge #(.INIT(1'b1)) u_dout (
    .clk(clk), .arst_n(arst_n), .d(link.dout),
    .q(dout_s), .rise(), .fall());

  // ---------------------------------
  // decode
  // ---------------------------------
  logic tick;
  logic [7:0] rx_byte;
  logic [7:0] cmd_crc;
  logic [2:0] nxt_idx;
  logic [7:0] tx_next;
  logic bad;
  logic is_data;

  assign tick = div_reg == 16'(HALF_CLKS - 1);
  assign rx_byte = {rx_reg, dout_s};
  assign cmd_crc = crc8(crc8(CRC_SEED, op_reg), arg_reg);
  assign nxt_idx = idx_reg + 3'd1;
  // host bytes: opcode, argument, crc in crc mode, then fill
  assign tx_next = (nxt_idx == 3'd1) ? arg_reg :
                   (mode_reg & (nxt_idx == 3'd2)) ? cmd_crc : FILL_BYTE;
  // position of the read data byte
  assign is_data = mode_reg ? (idx_reg == 3'd4) : (idx_reg == 3'd2);
  assign bad = (idx_reg == 3'd1) ? (rx_byte != op_reg) :
               (mode_reg & (idx_reg == 3'd2)) ? (rx_byte != arg_reg) :
               (mode_reg & (idx_reg == 3'd3)) ? (rx_byte != cmd_crc) :
               (mode_reg & (idx_reg == 3'd5)) ? (rx_byte != crc8(CRC_SEED, data_reg)) :
               1'b0;

  // ---------------------------------
  // sclk divider
  // ---------------------------------
  // the divider idles at zero so each frame starts a full half period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 16'd0;
    end else if (state_reg == H_IDLE || tick) begin
      div_reg <= 16'd0;
    end else begin
      div_reg <= div_reg + 16'd1;
    end
  end

  // ---------------------------------
  // frame engine
  // ---------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= H_IDLE;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      din_reg <= 1'b0;
      bit_reg <= 3'd0;
      idx_reg <= 3'd0;
      len_reg <= LEN_CMD;
      tx_reg <= 8'h00;
      rx_reg <= 7'd0;
      op_reg <= 8'h00;
      arg_reg <= 8'h00;
      data_reg <= 8'h00;
      mode_reg <= 1'b0;
      err_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            op_reg <= cmd_op;
            arg_reg <= cmd_arg;
            mode_reg <= crc_mode;
            // one register byte per frame, so a read is one byte longer, two with crc (data and its crc)
            len_reg <= crc_mode ? (op_is_rd(cmd_op) ? LEN_RD_CRC : LEN_CMD_CRC)
                                : (op_is_rd(cmd_op) ? LEN_RD : LEN_CMD);
            tx_reg <= cmd_op;
            data_reg <= IDLE_BYTE;
            err_reg <= 1'b0;
            idx_reg <= 3'd0;
            bit_reg <= 3'd0;
            cs_n_reg <= 1'b0;
            state_reg <= H_LEAD;
          end
        end
        H_LEAD: begin
          if (tick) begin
            state_reg <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick && !sclk_reg) begin
            // data changes on the rise, msb first
            sclk_reg <= 1'b1;
            din_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end else if (tick) begin
            sclk_reg <= 1'b0;
            rx_reg <= rx_byte[6:0];
            bit_reg <= bit_reg + 3'd1;
            if (bit_reg == 3'd7) begin
              err_reg <= err_reg | bad;
              if (is_data && op_is_rd(op_reg)) begin
                data_reg <= rx_byte;
              end
              idx_reg <= nxt_idx;
              tx_reg <= tx_next;
              if (nxt_idx == len_reg) begin
                state_reg <= H_TAIL;
              end
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            cs_n_reg <= 1'b1;
            valid_reg <= 1'b1;
            state_reg <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // requests are taken only in idle; keeping write opcodes in range is the requester's duty
  assign cmd_ready = state_reg == H_IDLE;
  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.din = din_reg;
  assign rsp_valid = valid_reg;
  assign rsp_data = data_reg;
  assign rsp_err = err_reg;
endmodule // ascd_host
`default_nettype wire

// ### hw/ascd_if.sv
/*
  serial link between host controller and decoder.
  assumes the bench resolves nothing: all four wires are one-way.
*/
`timescale 1ns/10ps
`default_nettype none
interface ascd_if;
  logic sclk;  // serial clock from host
  logic cs_n;  // frame select, low active
  logic din;   // host to device data
  logic dout;  // device data / ready line
  modport dev (input sclk, input cs_n, input din, output dout);
  modport host (output sclk, output cs_n, output din, input dout);
endinterface
`default_nettype wire

// ### hw/ascd_pkg.sv
/*
  shared constants, opcodes and crc helper for the serial command decoder.
  assumes both ends and the bench import it whole.
*/
`default_nettype none
package ascd_pkg;
  // -----------------------------
  // register space
  // -----------------------------
  localparam int NUM_REGS = 18;
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_ID = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_MODE3 = 5'h05;
  localparam int STAT_LOCK_BIT = 7;
  localparam int STAT_ERR_BIT = 6;
  localparam int MODE3_CRC_BIT = 5;
  localparam logic [17:0] RESTART_MASK = 18'h3_004c;
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    8'h00, 8'h01, 8'h24, 8'h01, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h40, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff};
  // -----------------------------
  // opcodes and fixed bytes
  // -----------------------------
  localparam logic [7:0] OP_SYS_OFS_CAL = 8'h16;
  localparam logic [7:0] OP_FS_CAL = 8'h17;
  localparam logic [7:0] OP_SELF_OFS_CAL = 8'h19;
  localparam logic [7:0] OP_RD_BASE = 8'h20;
  localparam logic [7:0] OP_WR_BASE = 8'h40;
  localparam logic [7:0] OP_LOCK = 8'hf2;
  localparam logic [7:0] OP_UNLOCK = 8'hf5;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [7:0] OUT_RANGE_BYTE = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'hff;
  // frame lengths in bytes
  localparam logic [2:0] LEN_CMD = 3'd2;
  localparam logic [2:0] LEN_RD = 3'd3;
  localparam logic [2:0] LEN_CMD_CRC = 3'd4;
  localparam logic [2:0] LEN_RD_CRC = 3'd6;
  // -----------------------------
  // timing
  // -----------------------------
  localparam int CLK_NS = 100;
  localparam int SCLK_HALF_NS = 800;
  localparam int SCLK_HALF_CLKS = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

  // opcode class tests: address sits in the low five bits
  function automatic logic op_is_rd(input logic [7:0] op);
    return op[7:5] == OP_RD_BASE[7:5];
  endfunction
  function automatic logic op_is_wr(input logic [7:0] op);
    return op[7:5] == OP_WR_BASE[7:5];
  endfunction

  // one byte through the crc, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[7] ^ d[i];
      r = {r[6:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ### hw/ascd_sync_edge.sv
/*
  two-flop synchroniser with edge detect on the settled copy.
  assumes a slow asynchronous input relative to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module ascd_sync_edge #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,    // system clock
  input wire logic arst_n, // async reset
  input wire logic d,      // async input
  output logic q,          // synchronised level
  output logic rise,       // one-cycle pulse
  output logic fall        // one-cycle pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // first flop feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
      last_reg <= INIT;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign q = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule // ascd_sync_edge
`default_nettype wire

// ### verification/ascd_link_props.sv
/*
  wire checks on the serial link between host end and device end.
  assumes sclk and cs_n come from host flops clocked by clk.
*/
`timescale 1ns/10ps
`default_nettype none
module ascd_link_props (
  input wire logic clk,    // system clock
  input wire logic arst_n, // async reset, low active
  input wire logic sclk,   // serial clock
  input wire logic cs_n,   // frame select
  input wire logic din,    // host data
  input wire logic dout    // device data
);
  logic sclk_reg;
  logic [5:0] nbit_reg;
  logic [47:0] di_reg;
  logic [47:0] dq_reg;
  wire sclk_fall = sclk_reg & ~sclk;
  // ------------------------------
  // frame capture
  // ------------------------------
  // bits are taken on falling sclk, where both ends hold them steady
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_reg <= 1'b0;
      nbit_reg <= 6'h00;
      di_reg <= 48'h0000_0000_0000;
      dq_reg <= 48'h0000_0000_0000;
    end else begin
      sclk_reg <= sclk;
      if (cs_n) begin
        nbit_reg <= 6'h00;
      end else if (sclk_fall) begin
        nbit_reg <= nbit_reg + 6'h01;
        di_reg <= {di_reg[46:0], din};
        dq_reg <= {dq_reg[46:0], dout};
      end
    end
  end
  // ------------------------------
  // link properties
  // ------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk moves outside a frame");
  a_frame_len_ok: assert property ($rose(cs_n) |-> nbit_reg inside {16, 24, 32, 48})
    else $error("frame length is not a whole command");
  a_cmd_answer: assert property ($rose(cs_n) && nbit_reg == 16 |->
    dq_reg[15:8] == 8'hff && dq_reg[7:0] == di_reg[15:8])
    else $error("short frame answer wrong");
  a_read_fill: assert property ($rose(cs_n) && nbit_reg == 24 |->
    di_reg[23:21] == 3'b001 && di_reg[7:0] == 8'h00 && dq_reg[23:16] == 8'hff && dq_reg[15:8] == di_reg[23:16])
    else $error("read frame fill or echo wrong");
  a_read_range: assert property ($rose(cs_n) && nbit_reg == 24 && di_reg[20:16] >= 5'd18 |->
    dq_reg[7:0] == 8'h00)
    else $error("unmapped read not zero");
  a_crc_echo: assert property ($rose(cs_n) && nbit_reg == 32 |->
    dq_reg[31:24] == 8'hff && dq_reg[23:16] == di_reg[31:24] && dq_reg[15:8] == di_reg[23:16] &&
    di_reg[7:0] == 8'h00)
    else $error("checked frame echo wrong");
  a_crc_read: assert property ($rose(cs_n) && nbit_reg == 48 |->
    di_reg[47:45] == 3'b001 && di_reg[23:0] == 24'h00_0000 && dq_reg[39:32] == di_reg[47:40])
    else $error("checked read frame wrong");
  a_crc_range: assert property ($rose(cs_n) && nbit_reg == 48 && di_reg[44:40] >= 5'd18 |->
    dq_reg[15:8] == 8'h00)
    else $error("checked unmapped read not zero");
  // the requester must keep write opcodes inside the register space
  a_wr_in_range: assert property ($rose(cs_n) && nbit_reg inside {16, 32} |->
    !((nbit_reg == 16 ? di_reg[15:8] : di_reg[31:24]) inside {[8'h52:8'h5f]}))
    else $error("write beyond register range");
  c_short: cover property ($rose(cs_n) && nbit_reg == 16);
  c_crc_cmd: cover property ($rose(cs_n) && nbit_reg == 32);
  c_read: cover property ($rose(cs_n) && nbit_reg == 24);
  c_crc_read: cover property ($rose(cs_n) && nbit_reg == 48);
endmodule // ascd_link_props
`default_nettype wire

// ### verification/test_adc_serial_command_decoder.sv
/*
  bench for the serial command decoder: host end and device end on
  one link, driven through the host request port and cal inputs.
  assumes one 10 mhz clock for both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module test_adc_serial_command_decoder;
  import ascd_pkg::*;
  logic clk, arst_n, cmd_valid, cal_wr, cmd_ready, rsp_valid, rsp_err, crc_mode, locked, err_flag;
  logic crc_flip;
  logic [7:0] cmd_op, cmd_arg, cal_data, rsp_data;
  logic [4:0] cal_addr;
  logic [3:0] pulse;
  logic [7:0] cal_op [3] = '{8'h16, 8'h17, 8'h19};
  int pulse_n [4];
  int errors;
  int n_checks;
  ascd_if link();
  // ------------------------------
  // both ends and the link checker
  // ------------------------------
  ascd_device #(.DEV_ID(8'h5c)) ascd_device_inst (.clk(clk), .arst_n(arst_n), .link(link.dev),
    .ready_n(1'b1), .cal_wr(cal_wr), .cal_addr(cal_addr), .cal_data(cal_data),
    .sys_ofs_cal(pulse[0]), .fs_cal(pulse[1]), .self_ofs_cal(pulse[2]), .conv_restart(pulse[3]),
    .locked(locked), .check_error_flag(err_flag), .crc_mode(crc_mode));
  ascd_host ascd_host_inst (.clk(clk), .arst_n(arst_n), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .crc_mode(crc_mode ^ crc_flip),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));
  ascd_link_props ascd_link_props_inst (.clk(clk), .arst_n(arst_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .dout(link.dout));
  // clock and pulse tallies
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // pulses are counted mid-cycle, where they have settled
  always @(negedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (pulse[i] === 1'b1) begin
        pulse_n[i]++;
      end
    end
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one frame; ready is sampled mid-cycle so the request edge is never raced
  task automatic frame(input logic [7:0] op, input logic [7:0] arg, input logic [7:0] exp);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    cmd_op <= op;
    cmd_arg <= arg;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000) begin
      errors++;
      print_verdict();
    end
    check(rsp_data, exp, "frame data");
    check({7'h00, rsp_err}, 8'h00, "frame error");
  endtask
  task automatic cal(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    cal_wr <= 1'b1;
    cal_addr <= a;
    cal_data <= d;
    @(posedge clk);
    cal_wr <= 1'b0;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {arst_n, cmd_valid, cal_wr, crc_flip, cmd_op, cmd_arg, cal_data, cal_addr} = '0;
    pulse_n = '{0, 0, 0, 0};
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    frame(8'h20, 8'h00, 8'h5c);
    for (int i = 1; i < 18; i++) begin
      frame(8'h20 | 8'(i), 8'h00, REG_RST[i]);
    end
    frame(8'h32, 8'h00, 8'h00);
    frame(8'h3f, 8'h00, 8'h00);
    frame(8'h47, 8'h5a, 8'hff);
    frame(8'h27, 8'h00, 8'h5a);
    frame(8'h28, 8'h00, 8'h00);
    frame(8'h42, 8'h25, 8'hff);
    frame(8'h22, 8'h00, 8'h25);
    check(8'(pulse_n[3]), 8'h01, "restart count");
    for (int i = 0; i < 3; i++) begin
      frame(cal_op[i], 8'h3c, 8'hff);
    end
    frame(8'hf2, 8'h00, 8'hff);
    for (int i = 0; i < 3; i++) begin
      check(8'(pulse_n[i]), 8'h01, "cal start count");
    end
    frame(8'h21, 8'h00, 8'h81);
    frame(8'h47, 8'ha5, 8'hff);
    cal(5'd7, 8'h99);
    frame(8'h27, 8'h00, 8'h5a);
    check({7'h00, locked}, 8'h01, "lock level");
    frame(8'hf5, 8'h00, 8'hff);
    cal(5'd7, 8'h99);
    frame(8'h27, 8'h00, 8'h99);
    frame(8'h21, 8'h00, 8'h01);
    frame(8'h45, 8'h20, 8'hff);
    check({7'h00, crc_mode}, 8'h01, "crc mode on");
    frame(8'h27, 8'h00, 8'h99);
    frame(8'h36, 8'h00, 8'h00);
    // host framing forced plain while the device checks: its fill byte fails the crc
    @(posedge clk);
    crc_flip <= 1'b1;
    frame(8'h21, 8'h00, 8'h00);
    @(posedge clk);
    crc_flip <= 1'b0;
    check({7'h00, err_flag}, 8'h01, "error flag set");
    frame(8'h21, 8'h00, 8'h41);
    frame(8'h41, 8'h01, 8'hff);
    frame(8'h16, 8'h77, 8'hff);
    frame(8'h45, 8'h00, 8'hff);
    frame(8'h25, 8'h00, 8'h00);
    check(8'(pulse_n[0]), 8'h02, "checked cal start");
    check({7'h00, err_flag}, 8'h00, "error flag");
    print_verdict();
  end
endmodule // test_adc_serial_command_decoder
`default_nettype wire
